/* File: aaao_defines.vh */
`ifndef AAAO_DEFINES_VH
`define AAAO_DEFINES_VH

// APB register byte offsets
`define AAAO_OFS_INSTR 8'h00
`define AAAO_OFS_ACCUM 8'h04
`define AAAO_OFS_FLAGS 8'h08
`define AAAO_OFS_BANK 8'h0C
`define AAAO_OFS_MADDR 8'h10
`define AAAO_OFS_MDATA 8'h14
`define AAAO_OFS_EXEC 8'h18

// Reset values
`define AAAO_RST_ACCUM 8'h00
`define AAAO_RST_FLAGS 5'h00
`define AAAO_RST_BANK 4'h0
`define AAAO_RST_MADDR 12'h000

// Flag bit positions in the flags register
`define AAAO_FLG_C 0
`define AAAO_FLG_DC 1
`define AAAO_FLG_Z 2
`define AAAO_FLG_OV 3
`define AAAO_FLG_N 4

// Exec status bit positions
`define AAAO_EXE_BUSY 0
`define AAAO_EXE_ILLEGAL 1

// Instruction word fields
`define AAAO_OPC6_HI 15
`define AAAO_OPC6_LO 10
`define AAAO_OPC8_LO 8
`define AAAO_DEST_BIT 9
`define AAAO_ACC_BIT 8
`define AAAO_FILE_HI 7

// Opcode patterns
`define AAAO_OPC_ADD 6'h09
`define AAAO_OPC_ADDC 6'h08
`define AAAO_OPC_ANDF 6'h05
`define AAAO_OPC_ANDL 8'h0B

// Operation select for the arithmetic unit
`define AAAO_ALU_ADD 2'h0
`define AAAO_ALU_ADDC 2'h1
`define AAAO_ALU_AND 2'h2

// Access bank: low file addresses map to bank 0, high ones to the top bank
`define AAAO_ACC_LOW_BANK 4'h0
`define AAAO_ACC_HIGH_BANK 4'hF

`endif

/* File: aaao_alu.v */
`timescale 1ns/10ps
`default_nettype none
`include "aaao_defines.vh"

module aaao_alu (
    // Operands
    input wire [1:0] op_sel,
    input wire [7:0] opnd_a,
    input wire [7:0] opnd_b,
    input wire carry_in,
    // Result and flags
    output reg [7:0] result,
    output reg flag_n,
    output reg flag_ov,
    output reg flag_c,
    output reg flag_dc,
    output reg flag_z
);
    reg [8:0] sum;
    reg [4:0] low_sum;
    reg cin;

    always @* begin
        cin = (op_sel == `AAAO_ALU_ADDC) ? carry_in : 1'b0;
        sum = {1'b0, opnd_a} + {1'b0, opnd_b} + {8'h00, cin};
        low_sum = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
        if (op_sel == `AAAO_ALU_AND) begin
            result = opnd_a & opnd_b;
        end else begin
            result = sum[7:0];
        end
        flag_c = sum[8];
        flag_dc = low_sum[4];
        // Signed overflow: like-signed operands give an unlike-signed sum
        flag_ov = (opnd_a[7] == opnd_b[7]) && (sum[7] != opnd_a[7]);
        flag_n = result[7];
        flag_z = (result == 8'h00);
    end
endmodule // aaao_alu
`default_nettype wire

/* File: aaao_core.v */
// Function
// - Opcode 0010 01da adds accumulator to file register; updates N, OV, C, DC, Z.
// - Destination bit 0 writes accumulator; bit 1 writes back the file register.
// - Access bit 0 uses the fixed access bank; bit 1 uses bank select.
// - Opcode 0010 00da adds accumulator, carry and file register; same flags.
// - Upper byte 0000 1011 is AND-with-literal; low byte is the literal.
// - AND-with-literal puts accumulator AND literal in accumulator; N, Z only.
// - Opcode 0001 01da ANDs accumulator with file register; N, Z only.
`timescale 1ns/10ps
`default_nettype none
`include "aaao_defines.vh"

module aaao_core #(
    parameter BANK_W = 4,
    parameter FILE_W = 8
) (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr
);
    localparam ADDR_W = BANK_W + FILE_W;
    localparam DEPTH = 1 << ADDR_W;

    // Execution phases
    localparam ST_IDLE = 3'd0;
    localparam ST_DECODE = 3'd1;
    localparam ST_READ = 3'd2;
    localparam ST_PROCESS = 3'd3;
    localparam ST_WRITE = 3'd4;

    reg [7:0] data_mem [0:DEPTH-1];

    reg [2:0] state_reg;
    reg [15:0] instr_reg;
    reg [7:0] accum_reg;
    reg [4:0] flags_reg;
    reg [BANK_W-1:0] bank_select_register;
    reg [ADDR_W-1:0] maddr_reg;
    reg illegal_reg;
    reg [1:0] alu_op_reg;
    reg dest_file_reg;
    reg [ADDR_W-1:0] eff_addr_reg;
    reg [7:0] operand_reg;
    reg [7:0] result_reg;
    reg [4:0] new_flags_reg;

    wire [7:0] alu_result;
    wire alu_n;
    wire alu_ov;
    wire alu_c;
    wire alu_dc;
    wire alu_z;
    wire apb_access;
    wire apb_commit;
    wire apb_wr;
    wire [4:0] flags_next;

    assign apb_access = psel && penable;
    assign apb_commit = apb_access && pready;
    assign apb_wr = apb_commit && pwrite;

    // Access bank splits at the file address top bit
    function [ADDR_W-1:0] eff_addr;
        input acc_bit;
        input [BANK_W-1:0] bank;
        input [FILE_W-1:0] file;
        begin
            if (acc_bit) begin
                eff_addr = {bank, file};
            end else if (file[`AAAO_FILE_HI]) begin
                eff_addr = {`AAAO_ACC_HIGH_BANK, file};
            end else begin
                eff_addr = {`AAAO_ACC_LOW_BANK, file};
            end
        end
    endfunction

    function [31:0] reg_read;
        input [7:0] ofs;
        begin
            case (ofs)
                `AAAO_OFS_INSTR: reg_read = {16'h0000, instr_reg};
                `AAAO_OFS_ACCUM: reg_read = {24'h000000, accum_reg};
                `AAAO_OFS_FLAGS: reg_read = {27'h0000000, flags_reg};
                `AAAO_OFS_BANK: reg_read = {28'h0000000, bank_select_register};
                `AAAO_OFS_MADDR: reg_read = {20'h00000, maddr_reg};
                `AAAO_OFS_MDATA: reg_read = {24'h000000, data_mem[maddr_reg]};
                `AAAO_OFS_EXEC: reg_read = {30'h00000000, illegal_reg,
                    (state_reg != ST_IDLE)};
                default: reg_read = 32'h00000000;
            endcase
        end
    endfunction

    function mapped;
        input [7:0] ofs;
        begin
            mapped = (ofs == `AAAO_OFS_INSTR) || (ofs == `AAAO_OFS_ACCUM) ||
                (ofs == `AAAO_OFS_FLAGS) || (ofs == `AAAO_OFS_BANK) ||
                (ofs == `AAAO_OFS_MADDR) || (ofs == `AAAO_OFS_MDATA) ||
                (ofs == `AAAO_OFS_EXEC);
        end
    endfunction

    function is_and_literal;
        input [15:0] word;
        begin
            is_and_literal =
                (word[`AAAO_OPC6_HI:`AAAO_OPC8_LO] == `AAAO_OPC_ANDL);
        end
    endfunction

    aaao_alu u_alu (
        .op_sel(alu_op_reg),
        .opnd_a(accum_reg),
        .opnd_b(operand_reg),
        .carry_in(flags_reg[`AAAO_FLG_C]),
        .result(alu_result),
        .flag_n(alu_n),
        .flag_ov(alu_ov),
        .flag_c(alu_c),
        .flag_dc(alu_dc),
        .flag_z(alu_z)
    );

    // Adds refresh all five flags; AND keeps carry, digit carry, overflow
    assign flags_next = (alu_op_reg == `AAAO_ALU_AND) ?
        {alu_n, flags_reg[`AAAO_FLG_OV], alu_z, flags_reg[`AAAO_FLG_DC],
        flags_reg[`AAAO_FLG_C]} :
        {alu_n, alu_ov, alu_z, alu_dc, alu_c};

    // Data memory: software port when idle, destination write in phase four
    always @(posedge pclk) begin
        if (apb_wr && paddr == `AAAO_OFS_MDATA) begin
            data_mem[maddr_reg] <= pwdata[7:0];
        end else if (state_reg == ST_WRITE && dest_file_reg) begin
            data_mem[eff_addr_reg] <= result_reg;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            instr_reg <= 16'h0000;
            accum_reg <= `AAAO_RST_ACCUM;
            flags_reg <= `AAAO_RST_FLAGS;
            bank_select_register <= `AAAO_RST_BANK;
            maddr_reg <= `AAAO_RST_MADDR;
            illegal_reg <= 1'b0;
            alu_op_reg <= `AAAO_ALU_ADD;
            dest_file_reg <= 1'b0;
            eff_addr_reg <= `AAAO_RST_MADDR;
            operand_reg <= 8'h00;
            result_reg <= 8'h00;
            new_flags_reg <= `AAAO_RST_FLAGS;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Bus waits while an instruction runs, so no write races the datapath
            if (apb_commit) begin
                pready <= 1'b0;
                pslverr <= 1'b0;
            end else if (apb_access && state_reg == ST_IDLE) begin
                pready <= 1'b1;
                pslverr <= !mapped(paddr);
                prdata <= pwrite ? 32'h00000000 : reg_read(paddr);
            end

            if (apb_wr) begin
                case (paddr)
                    `AAAO_OFS_INSTR: begin
                        instr_reg <= pwdata[15:0];
                        state_reg <= ST_DECODE;
                    end
                    `AAAO_OFS_ACCUM: accum_reg <= pwdata[7:0];
                    `AAAO_OFS_FLAGS: flags_reg <= pwdata[4:0];
                    `AAAO_OFS_BANK: bank_select_register <= pwdata[BANK_W-1:0];
                    `AAAO_OFS_MADDR: maddr_reg <= pwdata[ADDR_W-1:0];
                    default: begin
                    end
                endcase
            end

            case (state_reg)
                ST_DECODE: begin
                    dest_file_reg <= instr_reg[`AAAO_DEST_BIT];
                    eff_addr_reg <= eff_addr(instr_reg[`AAAO_ACC_BIT],
                        bank_select_register, instr_reg[FILE_W-1:0]);
                    illegal_reg <= 1'b0;
                    state_reg <= ST_READ;
                    if (is_and_literal(instr_reg)) begin
                        alu_op_reg <= `AAAO_ALU_AND;
                        dest_file_reg <= 1'b0;
                    end else begin
                        case (instr_reg[`AAAO_OPC6_HI:`AAAO_OPC6_LO])
                            `AAAO_OPC_ADD: alu_op_reg <= `AAAO_ALU_ADD;
                            `AAAO_OPC_ADDC: alu_op_reg <= `AAAO_ALU_ADDC;
                            `AAAO_OPC_ANDF: alu_op_reg <= `AAAO_ALU_AND;
                            default: begin
                                // Unsupported words set only the illegal status bit
                                illegal_reg <= 1'b1;
                                state_reg <= ST_IDLE;
                            end
                        endcase
                    end
                end
                ST_READ: begin
                    if (is_and_literal(instr_reg)) begin
                        operand_reg <= instr_reg[`AAAO_FILE_HI:0];
                    end else begin
                        operand_reg <= data_mem[eff_addr_reg];
                    end
                    state_reg <= ST_PROCESS;
                end
                ST_PROCESS: begin
                    result_reg <= alu_result;
                    new_flags_reg <= flags_next;
                    state_reg <= ST_WRITE;
                end
                ST_WRITE: begin
                    if (!dest_file_reg) begin
                        accum_reg <= result_reg;
                    end
                    flags_reg <= new_flags_reg;
                    state_reg <= ST_IDLE;
                end
                default: begin
                end
            endcase
        end
    end
endmodule // aaao_core
`default_nettype wire

/* File: aaao_core_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module aaao_core_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_answer_bounded: assert property ($rose(penable) |-> ##[1:6] pready)
        else $error("no answer in time");
    a_exec_four_phases: assert property (pready && pwrite && paddr == 8'h00
        && pwdata[15:8] == 8'h0B |=> !pready [*4])
        else $error("bus answered during execution");
    a_write_data_zero: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data on a write");
    a_unmapped_error: assert property (pready && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access not flagged");
    // Unaligned offsets are unmapped as well as those past the last register
    a_err_with_ready: assert property (pslverr |-> pready
        && (paddr > 8'h18 || paddr[1:0] != 2'b00))
        else $error("error without cause");
    a_flags_width: assert property (pready && !pwrite && paddr == 8'h08
        |-> prdata[31:5] == 27'h0)
        else $error("flags upper bits set");
    a_accum_width: assert property (pready && !pwrite && paddr == 8'h04
        |-> prdata[31:8] == 24'h0)
        else $error("accumulator upper bits set");
    c_err: cover property (pslverr);
    c_instr: cover property (pready && pwrite && paddr == 8'h00);
    c_accum: cover property (pready && !pwrite && paddr == 8'h04);
endmodule // aaao_core_chk
bind aaao_core aaao_core_chk i_aaao_core_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* File: aaao_host.sv */
`timescale 1ns/10ps
`default_nettype none
module aaao_host (
    // Clock
    input wire logic pclk,
    // APB master side
    output var logic psel,
    output var logic penable,
    output var logic pwrite,
    output var logic [7:0] paddr,
    output var logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Request held until pready is sampled high; the bench timeout ends a hang
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // aaao_host
`default_nettype wire

/* File: test_add_and_alu_ops.sv */
`timescale 1ns/10ps
`default_nettype none
module test_add_and_alu_ops;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_val;
    logic rd_err;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    always #10 pclk = ~pclk;
    aaao_host i_aaao_host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    aaao_core #(.BANK_W(4), .FILE_W(8)) i_aaao_core (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task print_verdict;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        i_aaao_host.xfer(1'b1, a, d, rd_val, rd_err);
    endtask
    task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        i_aaao_host.xfer(1'b0, a, 32'h0, rd_val, rd_err);
        check(name, rd_val, exp);
    endtask
    task t_reset;
        rd("accum", 8'h04, 32'h0);
        rd("flags", 8'h08, 32'h0);
        rd("bank", 8'h0C, 32'h0);
    endtask
    // Access bank with f above 0x7F lands in the top bank
    task t_add;
        wr(8'h10, 32'hFC2);
        wr(8'h14, 32'hC2);
        wr(8'h04, 32'h17);
        wr(8'h00, 32'h24C2);
        rd("accum", 8'h04, 32'hD9);
        rd("flags", 8'h08, 32'h10);
        rd("file kept", 8'h14, 32'hC2);
    endtask
    task t_addc;
        wr(8'h0C, 32'h3);
        wr(8'h10, 32'h340);
        wr(8'h14, 32'h02);
        wr(8'h04, 32'h4D);
        wr(8'h08, 32'h01);
        wr(8'h00, 32'h2340);
        rd("file sum", 8'h14, 32'h50);
        rd("accum kept", 8'h04, 32'h4D);
        rd("flags", 8'h08, 32'h02);
    endtask
    task t_andl;
        wr(8'h04, 32'hA3);
        wr(8'h08, 32'h0F);
        wr(8'h00, 32'h0B5F);
        rd("accum", 8'h04, 32'h03);
        rd("flags", 8'h08, 32'h0B);
    endtask
    task t_andf;
        wr(8'h04, 32'h17);
        wr(8'h08, 32'h1F);
        wr(8'h10, 32'hFC2);
        wr(8'h00, 32'h14C2);
        rd("accum", 8'h04, 32'h02);
        rd("flags", 8'h08, 32'h0B);
        rd("file", 8'h14, 32'hC2);
    endtask
    task t_odd;
        wr(8'h00, 32'hFFFF);
        rd("exec", 8'h18, 32'h2);
        rd("accum", 8'h04, 32'h02);
        rd("unmapped", 8'h1C, 32'h0);
        check("slverr", {31'h0, rd_err}, 32'h1);
    endtask
    // Access bank with f below 0x80 lands in bank 0 whatever bank select holds
    task t_ovf;
        wr(8'h10, 32'h040);
        wr(8'h14, 32'h80);
        wr(8'h04, 32'h80);
        wr(8'h08, 32'h00);
        wr(8'h00, 32'h2640);
        rd("file sum", 8'h14, 32'h00);
        rd("accum kept", 8'h04, 32'h80);
        rd("flags", 8'h08, 32'h0D);
        wr(8'h10, 32'h340);
        rd("banked file", 8'h14, 32'h50);
    endtask
    task t_andz;
        wr(8'h0C, 32'h1);
        wr(8'h10, 32'h155);
        wr(8'h14, 32'hF0);
        wr(8'h04, 32'h0F);
        wr(8'h08, 32'h10);
        wr(8'h00, 32'h1755);
        rd("file and", 8'h14, 32'h00);
        rd("accum kept", 8'h04, 32'h0F);
        rd("flags", 8'h08, 32'h04);
    endtask
    task t_mid_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        rd("exec", 8'h18, 32'h0);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            print_verdict;
        end
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_add;
        t_addc;
        t_andl;
        t_andf;
        t_odd;
        t_ovf;
        t_andz;
        t_mid_reset;
        print_verdict;
    end
endmodule // test_add_and_alu_ops
`default_nettype wire
